// File: core/scf_serial_clock_filter.sv
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Clock source bit only for async external
// - Source bit one selects timer outputs ANDed
// - Halving bit picks 16 or 8 per bit outside smart card, which uses 32
// - Filter enables rx async, i2c lines i2c
// - Filter off passes raw levels through
// - Start by low level or falling edge
// - Extended bits writable only when disabled
// - Fastest sync setting adds idle bit
// - External clock edges form async base clock
// - Smart card fastest bit is 64 cycles
// - Divider and prescale set base clock
module scf_serial_clock_filter
  import scf_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [DATA_W-1:0] s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [DATA_W-1:0]      s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  input  wire logic              rx_data_pin_in,
  input  wire logic              i2c_clock_pin_in,
  input  wire logic              i2c_data_pin_in,
  input  wire logic              ext_clock_pin_in,
  input  wire logic              timer_a_compare_out_in,
  input  wire logic              timer_b_compare_out_in,
  output logic                   sync_clock_out,
  output logic                   i2c_clock_int_out,
  output logic                   i2c_data_int_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} scf_rx_e;

  // Address decode shared by the read and write paths
  function automatic scf_sel_e decode(input logic [ADDR_W-1:0] addr);
    scf_sel_e s;
    s = SEL_NONE;
    if (addr == CTRL_ADDR)   s = SEL_CTRL;
    if (addr == STATUS_ADDR) s = SEL_STAT;
    if (addr == RXDATA_ADDR) s = SEL_DATA;
    if (addr == XMODE_ADDR)  s = SEL_XMODE;
    return s;
  endfunction

  scf_ctrl_s        ctrl_ff;
  scf_xmode_s       xmode_ff;
  scf_mode_e        mode;
  logic             aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [DATA_W-1:0] wdata_ff, rdata_ff;
  logic [3:0]       wstrb_ff;
  logic [1:0]       bresp_ff, rresp_ff;
  logic             do_wr, do_rd, xmode_wr;
  scf_sel_e         wsel, rsel;
  logic [5:0]       sync1_ff, sync2_ff;
  logic [FILT_LEN-1:0] hist_ff [3];
  logic [2:0]       filt_ff, filt_en, line_int;
  logic             use_ext, src_lvl, src_prev_ff, base_tick;
  logic [15:0]      div_base, div_lim, div_cnt_ff, since_ff;
  logic             primed_ff;
  logic [5:0]       bits_per, base_cnt_ff;
  logic [2:0]       bit_idx_ff;
  logic [7:0]       shift_ff, pend_data_ff;
  logic             pend_ff, rx_prev_ff, rx_on, start_go, fifo_in_ready, fifo_out_valid;
  logic [7:0]       fifo_out_data;
  scf_rx_e          st_ff;
  logic [4:0]       sclk_cnt_ff;
  logic             sync_clk_ff, sync_gap;

  assign mode = scf_mode_e'(ctrl_ff.mode);

  // Write channel acceptance, either order
  assign s_axi_awready_out = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready_out  = !w_hold_ff && !bvalid_ff;
  assign s_axi_bvalid_out  = bvalid_ff;
  assign s_axi_bresp_out   = bresp_ff;
  assign do_wr = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wsel  = decode(awaddr_ff);
  assign xmode_wr = do_wr && (wsel == SEL_XMODE) && wstrb_ff[0];

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= '0;
      wstrb_ff   <= 4'h0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata_in;
        wstrb_ff  <= s_axi_wstrb_in;
      end
      if (do_wr) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_ff && s_axi_bready_in) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Control register, byte lanes 0 and 1
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_ff <= scf_ctrl_s'(CTRL_RESET);
    end else if (do_wr && (wsel == SEL_CTRL)) begin
      if (wstrb_ff[0]) ctrl_ff[7:0]  <= wdata_ff[7:0];
      if (wstrb_ff[1]) ctrl_ff[15:8] <= wdata_ff[15:8];
    end
  end

  // Extended mode register, locked while either direction is enabled
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xmode_ff <= scf_xmode_s'(XMODE_RESET);
    end else if (xmode_wr && !ctrl_ff.tx_enable && !ctrl_ff.rx_enable) begin
      xmode_ff <= scf_xmode_s'(wdata_ff[7:0] & XMODE_WR_MASK);
    end
  end

  // Read channel; a data read pops the receive buffer
  assign s_axi_arready_out = !rvalid_ff;
  assign s_axi_rvalid_out  = rvalid_ff;
  assign s_axi_rdata_out   = rdata_ff;
  assign s_axi_rresp_out   = rresp_ff;
  assign do_rd = s_axi_arvalid_in && !rvalid_ff;
  assign rsel  = decode(s_axi_araddr_in);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end else if (do_rd) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      rdata_ff  <= '0;
      case (rsel)
        SEL_CTRL: rdata_ff[15:0] <= ctrl_ff;
        SEL_STAT: begin
          rdata_ff[STAT_NEMPTY_BIT] <= fifo_out_valid;
          rdata_ff[STAT_BUSY_BIT]   <= (st_ff != ST_IDLE);
          rdata_ff[STAT_PEND_BIT]   <= pend_ff;
        end
        SEL_DATA: rdata_ff[7:0] <= fifo_out_valid ? fifo_out_data : 8'h00;
        SEL_XMODE: rdata_ff[7:0] <= xmode_ff;
        default:  rdata_ff <= '0;
      endcase
    end else if (rvalid_ff && s_axi_rready_in) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Two-stage synchronisers for all pins
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_ff <= 6'h3F;
      sync2_ff <= 6'h3F;
    end else begin
      sync1_ff <= {timer_b_compare_out_in, timer_a_compare_out_in, ext_clock_pin_in,
                   i2c_data_pin_in, i2c_clock_pin_in, rx_data_pin_in};
      sync2_ff <= sync1_ff;
    end
  end

  // Filter applies to rx in async and to both i2c lines in i2c mode
  assign filt_en[0] = xmode_ff.noise_filter_en && (mode == MODE_ASYNC);
  assign filt_en[1] = xmode_ff.noise_filter_en && (mode == MODE_I2C);
  assign filt_en[2] = filt_en[1];

  // Output follows only after three agreeing samples
  for (genvar g = 0; g < 3; g++) begin : g_filt
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        hist_ff[g] <= '1;
        filt_ff[g] <= 1'b1;
      end else begin
        hist_ff[g] <= {hist_ff[g][FILT_LEN-2:0], sync2_ff[g]};
        if (&hist_ff[g])  filt_ff[g] <= 1'b1;
        if (~|hist_ff[g]) filt_ff[g] <= 1'b0;
      end
    end
    assign line_int[g] = filt_en[g] ? filt_ff[g] : sync2_ff[g];
  end

  assign i2c_clock_int_out = line_int[1];
  assign i2c_data_int_out  = line_int[2];

  // External base clock only in async with external clock enable
  assign use_ext  = (mode == MODE_ASYNC) && ctrl_ff.clk_enable[1];
  assign src_lvl  = xmode_ff.async_clock_source_sel ? (sync2_ff[4] & sync2_ff[5]) : sync2_ff[3];
  assign div_base = {8'h00, ctrl_ff.bit_rate_divider} + 16'h0001;
  assign div_lim  = (div_base << {ctrl_ff.prescale, 1'b1}) - 16'h0001;
  // At or past the limit, so a smaller divider written mid-count cannot stall the tick
  assign base_tick = use_ext ? (src_lvl && !src_prev_ff) : (div_cnt_ff >= div_lim);

  // Base clock generator
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_prev_ff <= 1'b0;
      div_cnt_ff  <= 16'h0000;
    end else begin
      src_prev_ff <= src_lvl;
      if (use_ext || base_tick) div_cnt_ff <= 16'h0000;
      else div_cnt_ff <= div_cnt_ff + 16'h0001;
    end
  end

  // Base clocks per bit
  always_comb begin
    bits_per = BASE_PER_BIT_NORM;
    if (mode == MODE_SMART) bits_per = BASE_PER_BIT_SMART;
    else if (xmode_ff.base_clock_halving_sel) bits_per = BASE_PER_BIT_HALF;
  end

  // Start recognition by level or by falling edge
  assign rx_on    = ctrl_ff.rx_enable && ((mode == MODE_ASYNC) || (mode == MODE_SMART));
  assign start_go = rx_on && (st_ff == ST_IDLE) && !pend_ff && !line_int[0] &&
                    (!xmode_ff.edge_sel || rx_prev_ff);

  // Receive sequencer
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff       <= ST_IDLE;
      base_cnt_ff <= 6'h00;
      bit_idx_ff  <= 3'h0;
      shift_ff    <= 8'h00;
      rx_prev_ff  <= 1'b1;
      pend_ff     <= 1'b0;
      pend_data_ff <= 8'h00;
    end else begin
      rx_prev_ff <= line_int[0];
      if (pend_ff && fifo_in_ready) pend_ff <= 1'b0;
      if (!rx_on) begin
        st_ff <= ST_IDLE;
      end else begin
        case (st_ff)
          ST_IDLE: begin
            if (start_go) begin
              st_ff       <= ST_START;
              base_cnt_ff <= 6'h00;
            end
          end
          ST_START: begin
            if (base_tick) begin
              base_cnt_ff <= base_cnt_ff + 6'h01;
              if (base_cnt_ff == (bits_per >> 1) - 6'h01) begin
                base_cnt_ff <= 6'h00;
                bit_idx_ff  <= 3'h0;
                st_ff       <= line_int[0] ? ST_IDLE : ST_DATA;
              end
            end
          end
          ST_DATA: begin
            if (base_tick) begin
              base_cnt_ff <= base_cnt_ff + 6'h01;
              if (base_cnt_ff == bits_per - 6'h01) begin
                base_cnt_ff <= 6'h00;
                shift_ff    <= {line_int[0], shift_ff[7:1]};
                bit_idx_ff  <= bit_idx_ff + 3'h1;
                if ({1'b0, bit_idx_ff} == FRAME_BITS - 4'h1) st_ff <= ST_STOP;
              end
            end
          end
          ST_STOP: begin
            if (base_tick) begin
              base_cnt_ff <= base_cnt_ff + 6'h01;
              if (base_cnt_ff == bits_per - 6'h01) begin
                st_ff <= ST_IDLE;
                if (line_int[0]) begin
                  pend_ff      <= 1'b1;
                  pend_data_ff <= shift_ff;
                end
              end
            end
          end
          default: st_ff <= ST_IDLE;
        endcase
      end
    end
  end

  scf_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (pend_ff),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (pend_data_ff),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (do_rd && (rsel == SEL_DATA)),
    .out_data_out  (fifo_out_data)
  );

  // Synchronous clock output; fastest setting stops it for one bit
  assign sync_gap = (ctrl_ff.bit_rate_divider == 8'h00) && (ctrl_ff.prescale == 2'b00);
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_cnt_ff <= 5'h00;
      sync_clk_ff <= 1'b1;
    end else if (!(ctrl_ff.tx_enable && (mode == MODE_SYNC) && !ctrl_ff.clk_enable[1])) begin
      sclk_cnt_ff <= 5'h00;
      sync_clk_ff <= 1'b1;
    end else if (base_tick) begin
      if (sclk_cnt_ff < SYNC_HALF_PER_FRAME) sync_clk_ff <= !sync_clk_ff;
      else sync_clk_ff <= 1'b1;
      if (sclk_cnt_ff == SYNC_HALF_PER_FRAME - 5'h01 + (sync_gap ? SYNC_HALF_IDLE : 5'h00))
        sclk_cnt_ff <= 5'h00;
      else sclk_cnt_ff <= sclk_cnt_ff + 5'h01;
    end
  end
  assign sync_clock_out = sync_clk_ff;

  // Cycles between internal base ticks, for checking
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      since_ff  <= 16'h0000;
      primed_ff <= 1'b0;
    end else begin
      since_ff <= base_tick ? 16'h0000 : since_ff + 16'h0001;
      if (do_wr && (wsel == SEL_CTRL)) primed_ff <= 1'b0;
      else if (base_tick) primed_ff <= 1'b1;
    end
  end

  AST_XMODE_LOCK: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    xmode_wr && (ctrl_ff.tx_enable || ctrl_ff.rx_enable) |=> $stable(xmode_ff))
    else $error("extended mode changed while enabled");
  AST_RSV_ZERO: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    xmode_ff.rsv3_1 == 3'h0 && !xmode_ff.rsv6)
    else $error("reserved extended bits set");
  AST_EXT_ONLY_ASYNC: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (mode != MODE_ASYNC) && primed_ff && base_tick |-> since_ff == div_lim)
    else $error("external source used outside async");
  AST_TIMER_AND: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    base_tick && use_ext && xmode_ff.async_clock_source_sel |-> sync2_ff[4] && sync2_ff[5] && !src_prev_ff)
    else $error("timer tick without both compare outputs");
  AST_FILT_HOLD: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    filt_en[0] && !(&hist_ff[0]) && (|hist_ff[0]) |=> filt_ff[0] == $past(filt_ff[0]))
    else $error("filter passed a short pulse");
  AST_FILT_OFF: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !filt_en[1] |-> i2c_clock_int_out == sync2_ff[1] && (filt_en[2] || i2c_data_int_out == sync2_ff[2]))
    else $error("raw level not passed");
  AST_EDGE_START: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_ff == ST_IDLE) && rx_on ##1 (st_ff == ST_START) |-> !$past(line_int[0]) &&
      (!$past(xmode_ff.edge_sel) || $past(rx_prev_ff)))
    else $error("start taken without low level or edge");
  AST_SYNC_GAP: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    sclk_cnt_ff >= SYNC_HALF_PER_FRAME |-> sync_gap && sync_clk_ff)
    else $error("sync clock ran in idle gap");
  AST_DIV_PERIOD: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    base_tick && !use_ext && primed_ff && $stable(ctrl_ff) |-> since_ff == div_lim)
    else $error("base tick spacing wrong");
endmodule // scf_serial_clock_filter
`default_nettype wire

// File: core/scf_pkg.sv
package scf_pkg;
  // Bus geometry
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  // Extended mode register index and its byte address
  localparam logic [31:0] XMODE_INDEX = 32'h0008A027;
  localparam logic [31:0] XMODE_ADDR  = {XMODE_INDEX[29:0], 2'b00};
  localparam logic [31:0] CTRL_ADDR   = 32'h00000000;
  localparam logic [31:0] STATUS_ADDR = 32'h00000004;
  localparam logic [31:0] RXDATA_ADDR = 32'h00000008;
  // Extended mode field positions and reset value
  localparam int XMODE_SRC_BIT  = 0;
  localparam int XMODE_HALF_BIT = 4;
  localparam int XMODE_FILT_BIT = 5;
  localparam int XMODE_EDGE_BIT = 7;
  localparam logic [7:0] XMODE_RESET    = 8'h00;
  localparam logic [7:0] XMODE_WR_MASK  = 8'hB1;
  // Control register layout and reset value
  localparam logic [15:0] CTRL_RESET = 16'hFF00;
  // Status bit positions
  localparam int STAT_NEMPTY_BIT = 0;
  localparam int STAT_BUSY_BIT   = 1;
  localparam int STAT_PEND_BIT   = 2;
  // Responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Base clock cycles per bit and frame figures
  localparam logic [5:0] BASE_PER_BIT_NORM  = 6'h10;
  localparam logic [5:0] BASE_PER_BIT_HALF  = 6'h08;
  localparam logic [5:0] BASE_PER_BIT_SMART = 6'h20;
  localparam logic [3:0] FRAME_BITS         = 4'h8;
  localparam logic [4:0] SYNC_HALF_PER_FRAME = 5'h10;
  localparam logic [4:0] SYNC_HALF_IDLE      = 5'h02;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 8;
  localparam int FILT_LEN   = 3;

  typedef enum logic [1:0] {MODE_ASYNC, MODE_SYNC, MODE_SMART, MODE_I2C} scf_mode_e;

  typedef struct packed {
    logic       edge_sel;
    logic       rsv6;
    logic       noise_filter_en;
    logic       base_clock_halving_sel;
    logic [2:0] rsv3_1;
    logic       async_clock_source_sel;
  } scf_xmode_s;

  typedef struct packed {
    logic [7:0] bit_rate_divider;
    logic [1:0] prescale;
    logic [1:0] clk_enable;
    logic [1:0] mode;
    logic       rx_enable;
    logic       tx_enable;
  } scf_ctrl_s;

  typedef enum logic [2:0] {SEL_CTRL, SEL_STAT, SEL_DATA, SEL_XMODE, SEL_NONE} scf_sel_e;
endpackage

// File: core/scf_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module scf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW:0]      wr_ptr_ff;
  logic [PW:0]      rd_ptr_ff;
  logic             push;
  logic             pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready_out  = !((wr_ptr_ff[PW] != rd_ptr_ff[PW]) && (wr_ptr_ff[PW-1:0] == rd_ptr_ff[PW-1:0]));
  assign out_valid_out = (wr_ptr_ff != rd_ptr_ff);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem_ff[rd_ptr_ff[PW-1:0]];

  // Storage
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff[PW-1:0]] <= in_data_in;
    end
  end

  // Pointers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)  rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end
endmodule // scf_fifo
`default_nettype wire

// File: verification/scf_peer_model.sv
`timescale 1ns/100ps
`default_nettype none
// Remote sender: async frames timed by core cycles or by its own clock pins
module scf_peer_model (
  input  wire logic core_clk_in,
  output logic      rx_line_out,
  output logic      ext_clk_out,
  output logic      tmr_a_out,
  output logic      tmr_b_out
);
  // Idle line high, clock pins stand still low outside frames
  initial begin
    rx_line_out = 1'b1;
    ext_clk_out = 1'b0;
    tmr_a_out   = 1'b0;
    tmr_b_out   = 1'b0;
  end
  // Hold a level for len units: cycles, or 8-cycle ticks on ext or both timers
  task automatic hold(input logic v, input int kind, input int len);
    rx_line_out <= v;
    repeat (len) begin
      if (kind == 0) begin
        @(posedge core_clk_in);
      end else begin
        repeat (2) @(posedge core_clk_in);
        // Lone first-timer pulse: must not tick the receiver
        tmr_a_out   <= (kind == 2);
        repeat (2) @(posedge core_clk_in);
        tmr_a_out   <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        ext_clk_out <= (kind == 1);
        tmr_a_out   <= (kind == 2);
        tmr_b_out   <= (kind == 2);
        repeat (2) @(posedge core_clk_in);
        ext_clk_out <= 1'b0;
        tmr_a_out   <= 1'b0;
        tmr_b_out   <= 1'b0;
      end
    end
  endtask
  // Start bit, eight data bits first bit lowest, stop bit
  task automatic send(input logic [7:0] d, input int kind, input int len);
    hold(1'b0, kind, len);
    for (int i = 0; i < 8; i++) hold(d[i], kind, len);
    hold(1'b1, kind, len);
  endtask
  // Force the line, used for a break
  task automatic line(input logic v);
    rx_line_out <= v;
  endtask
endmodule // scf_peer_model
`default_nettype wire

// File: verification/scf_serial_clock_filter_test.sv
`timescale 1ns/100ps
`default_nettype none
module scf_serial_clock_filter_test
  import scf_pkg::*;
;
  logic        clk, rst_n, awv, wv, bre, arv, rre, i2c_c, i2c_d;
  logic [31:0] awa, wd, ara;
  logic        awr, wrd, bv, arr, rv, rxl, ext, ta, tb, sck, ic_o, id_o;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          n_mismatch, cmp_count;
  logic [15:0] c_ctrl [8] = '{16'h0, 16'h0, 16'h0100, 16'h0040, 16'h0, 16'h0030, 16'h0020, 16'h0008};
  logic [7:0]  c_xmode [8] = '{8'h00, 8'h90, 8'h00, 8'h20, 8'h01, 8'h00, 8'h01, 8'h00};
  int          c_kind [8] = '{0, 0, 0, 0, 0, 1, 2, 0};
  int          c_len  [8] = '{32, 16, 64, 128, 32, 16, 16, 64};
  logic [7:0]  c_dat  [8] = '{8'h3C, 8'hA5, 8'h5A, 8'h81, 8'hC3, 8'h96, 8'h69, 8'hE7};

  scf_serial_clock_filter DUT (
    .core_clk_in(clk), .rst_n_in(rst_n),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
    .rx_data_pin_in(rxl), .i2c_clock_pin_in(i2c_c), .i2c_data_pin_in(i2c_d),
    .ext_clock_pin_in(ext), .timer_a_compare_out_in(ta), .timer_b_compare_out_in(tb),
    .sync_clock_out(sck), .i2c_clock_int_out(ic_o), .i2c_data_int_out(id_o)
  );
  scf_peer_model u_peer (
    .core_clk_in(clk), .rx_line_out(rxl), .ext_clk_out(ext), .tmr_a_out(ta), .tmr_b_out(tb)
  );

  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Write with both channels offered together, response checked
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    done = 0;
    while (!done) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
      if (bv) begin
        bre <= 1'b0;
        chk(32'(bresp), 32'(er));
        done = 1;
      end
    end
  endtask

  // Read and compare data and response
  task automatic rc(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit done;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    done = 0;
    while (!done) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        rre <= 1'b0;
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
        done = 1;
      end
    end
  endtask

  // Reset values, unmapped place, reserved bits
  task automatic t_regs;
    rc(CTRL_ADDR, 32'h0000FF00, RESP_OKAY);
    rc(XMODE_ADDR, 32'h0, RESP_OKAY);
    rc(32'h10, 32'h0, RESP_SLVERR);
    wr(32'h10, 32'hFF, RESP_SLVERR);
    wr(XMODE_ADDR, 32'hFF, RESP_OKAY);
    rc(XMODE_ADDR, 32'hB1, RESP_OKAY);
  endtask

  // Extended bits frozen while either enable is set
  task automatic t_lock;
    for (int i = 1; i < 3; i++) begin
      wr(CTRL_ADDR, 32'(i), RESP_OKAY);
      wr(XMODE_ADDR, 32'h0, RESP_OKAY);
      rc(XMODE_ADDR, 32'hB1, RESP_OKAY);
    end
    wr(CTRL_ADDR, 32'h0, RESP_OKAY);
    wr(XMODE_ADDR, 32'h0, RESP_OKAY);
    rc(XMODE_ADDR, 32'h0, RESP_OKAY);
  endtask

  // Receive under several rates, each clock source, filter on and off, in async and smart card modes
  task automatic t_rx;
    for (int i = 0; i < 8; i++) begin
      wr(CTRL_ADDR, 32'h0, RESP_OKAY);
      wr(XMODE_ADDR, {24'h0, c_xmode[i]}, RESP_OKAY);
      wr(CTRL_ADDR, {16'h0, c_ctrl[i] | 16'h0002}, RESP_OKAY);
      u_peer.send(c_dat[i], c_kind[i], c_len[i]);
      repeat (40) @(posedge clk);
      rc(RXDATA_ADDR, {24'h0, c_dat[i]}, RESP_OKAY);
    end
  endtask

  // Fastest synchronous clock: eight falling edges span nine bit times
  task automatic t_sync;
    time t0;
    wr(CTRL_ADDR, 32'h0005, RESP_OKAY);
    @(negedge sck);
    t0 = $time;
    repeat (8) @(negedge sck);
    chk(32'(($time - t0) / 25), 32'd36);
    wr(CTRL_ADDR, 32'h0, RESP_OKAY);
  endtask

  // Line low before enabling: level start fires, edge start waits
  task automatic t_start;
    u_peer.line(1'b0);
    wr(XMODE_ADDR, 32'h80, RESP_OKAY);
    wr(CTRL_ADDR, 32'h2, RESP_OKAY);
    repeat (20) @(posedge clk);
    rc(STATUS_ADDR, 32'h0, RESP_OKAY);
    wr(CTRL_ADDR, 32'h0, RESP_OKAY);
    wr(XMODE_ADDR, 32'h0, RESP_OKAY);
    wr(CTRL_ADDR, 32'h2, RESP_OKAY);
    repeat (20) @(posedge clk);
    rc(STATUS_ADDR, 32'h2, RESP_OKAY);
    wr(CTRL_ADDR, 32'h0, RESP_OKAY);
    u_peer.line(1'b1);
  endtask

  // Low pulse on both bus pins, report whether both internal lines went low
  task automatic pulse(input int len, input logic ex);
    logic seen;
    seen = 1'b0;
    i2c_c <= 1'b0;
    i2c_d <= 1'b0;
    for (int k = 0; k < len + 12; k++) begin
      @(posedge clk);
      if (k == len - 1) begin
        i2c_c <= 1'b1;
        i2c_d <= 1'b1;
      end
      if ({ic_o, id_o} === 2'b00) seen = 1'b1;
    end
    chk(32'(seen), 32'(ex));
  endtask

  task automatic t_filt;
    wr(CTRL_ADDR, 32'h000C, RESP_OKAY);
    pulse(1, 1'b1);
    wr(XMODE_ADDR, 32'h20, RESP_OKAY);
    pulse(2, 1'b0);
    pulse(6, 1'b1);
    wr(XMODE_ADDR, 32'h0, RESP_OKAY);
    wr(CTRL_ADDR, 32'h0, RESP_OKAY);
  endtask

  // Main sequence
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    {awv, wv, bre, arv, rre} = '0;
    {i2c_c, i2c_d} = 2'b11;
    awa = '0;
    wd = '0;
    ara = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_lock;
    t_rx;
    t_sync;
    t_start;
    t_filt;
    final_report;
  end

  // Watchdog
  initial begin
    #1000000;
    n_mismatch++;
    final_report;
  end
endmodule // scf_serial_clock_filter_test
`default_nettype wire
